// >>> src/ssr_link_if.sv
// receive word handed from the serial clock domain
`timescale 1ns/1ps
interface ssr_link_if #(parameter int WORD_W = 16);
  logic [WORD_W-1:0] rx_word; // word shifted in, stable while done
  logic              rx_done; // level, full word received
  modport rx   (output rx_word, output rx_done);
  modport core (input rx_word, input rx_done);
endinterface : ssr_link_if

// >>> src/ssr_pkg.sv
// constants for the serial status readout block
package ssr_pkg;
  // word geometry
  localparam int WORD_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 12;
  localparam int NUM_CH = 5;
  localparam int NUM_IN = 4;
  localparam int OC_W   = 3;
  // register addresses carried in the top nibble
  localparam logic [3:0] REG_QUICK = 4'h1;
  localparam logic [3:0] REG_CH1   = 4'h2;
  localparam logic [3:0] REG_CH5   = 4'h6;
  localparam logic [3:0] REG_DEV   = 4'h7;
  localparam logic [3:0] REG_IO    = 4'h8;
  localparam logic [3:0] REG_ID    = 4'h9;
  localparam logic [3:0] REG_TEST  = 4'hf;
  // bits shared by addresses 1..7
  localparam int POS_FM   = 11;
  localparam int POS_DSF  = 10;
  localparam int POS_OVERLOAD_SUMMARY_FLAG = 9;
  localparam int POS_OLF  = 8;
  // quick status layout
  localparam int POS_CPF  = 7;
  localparam int POS_RCF  = 6;
  localparam int POS_PWM_CLOCK_FAIL_FLAG = 5;
  localparam int POS_QS   = 0;
  // channel detail layout
  localparam int POS_OTS   = 6;
  localparam int POS_OTW   = 5;
  localparam int POS_OC    = 2;
  localparam int POS_OLON  = 1;
  localparam int POS_OLOFF = 0;
  // device flag layout
  localparam int POS_TMF  = 4;
  localparam int POS_OVF  = 3;
  localparam int POS_UVF  = 2;
  localparam int POS_SERIAL_LINK_FAIL_FLAG = 1;
  localparam int POS_LIMP = 0;
  // pin level layout
  localparam int POS_TOGGLE = 9;
  localparam int POS_DIN    = 5;
  localparam int POS_CMP    = 0;
  // identification layout
  localparam int POS_ID_UVF  = 10;
  localparam int POS_ID_TYPE = 0;
  localparam int POS_ID_FAM  = 3;
  localparam int POS_ID_REV  = 5;
  // reset values
  localparam logic RCF_RST  = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  // overcurrent codes
  localparam logic [2:0] OC_NONE   = 3'h0;
  localparam logic [2:0] OC_HI1    = 3'h1;
  localparam logic [2:0] OC_HI2    = 3'h2;
  localparam logic [2:0] OC_HI3    = 3'h3;
  localparam logic [2:0] OC_LO     = 3'h4;
  localparam logic [2:0] OC_ONDMD  = 3'h5;
  localparam logic [2:0] OC_SEVERE = 3'h6;
  // identification values, arbitrary
  localparam logic [2:0] ID_TYPE = 3'h7;
  localparam logic [1:0] ID_FAM  = 2'h1;
  localparam logic [2:0] ID_REV  = 3'h1;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int DGL_TIME_NS   = 2000;
  localparam int DGL_CYC = (DGL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : ssr_pkg

// >>> src/ssr_sclk_rx.sv
// serial input shifter running on the link clock
`timescale 1ns/1ps
module ssr_sclk_rx #(
  parameter int WORD_W = 16
) (
  input wire logic sclk_link, // link clock from the master
  input wire logic cs_n_pin,  // frame select, low active
  input wire logic si_pin,    // serial data in
  ssr_link_if.rx   link       // toward the core domain
);
  localparam int CW = $clog2(WORD_W + 1);

  logic [WORD_W-1:0] sh_q;   // input shift register
  logic [CW-1:0]     cnt_q;  // bits taken this frame
  logic              done_q; // word complete

  // frame select clears count; no sclk edges outside frames
  always_ff @(negedge sclk_link or posedge cs_n_pin) begin
    if (cs_n_pin) begin
      cnt_q  <= '0;
      done_q <= 1'b0;
    end else if (cnt_q < CW'(WORD_W)) begin
      cnt_q  <= cnt_q + 1'b1;
      done_q <= (cnt_q == CW'(WORD_W - 1));
    end
  end

  // data sampled on falling edge, extra bits ignored
  always_ff @(negedge sclk_link) begin
    if (!cs_n_pin && cnt_q < CW'(WORD_W)) begin
      sh_q <= {sh_q[WORD_W-2:0], si_pin};
    end
  end

  assign link.rx_word = sh_q;
  assign link.rx_done = done_q;
endmodule : ssr_sclk_rx

// >>> src/ssr_status_readout.sv
// serial status word builder and shifter
`timescale 1ns/1ps
module ssr_status_readout
  import ssr_pkg::*;
#(
  parameter int NUM_CH  = ssr_pkg::NUM_CH,
  parameter int NUM_IN  = ssr_pkg::NUM_IN,
  parameter int DGL_CYC = ssr_pkg::DGL_CYC
) (
  input  wire logic                        mclk,          // core clock
  input  wire logic                        rst_n,         // sync reset, low
  input  wire logic                        sclk_link,     // link clock
  input  wire logic                        cs_n_pin,      // frame select
  input  wire logic                        si_pin,        // serial in
  output logic                             so_o,          // serial out
  output logic                             so_oe_o,       // serial out enable
  input  wire logic [3:0]                  next_addr_i,   // address for next frame
  output logic [ssr_pkg::WORD_W-1:0]       rx_word_o,     // received word
  output logic                             rx_valid_o,    // one-cycle strobe
  input  wire logic                        fail_op_i,     // fail operation level
  input  wire logic                        charge_pump_i, // charge pump event
  input  wire logic                        clk_fail_i,    // pwm clock fail event
  input  wire logic                        test_act_i,    // test activation event
  input  wire logic                        supply_high_i, // overvoltage event
  input  wire logic                        supply_low_i,  // undervoltage event
  input  wire logic                        link_fail_i,   // serial fail event
  input  wire logic [NUM_CH-1:0]           ots_i,         // thermal shutdown
  input  wire logic [NUM_CH-1:0]           otw_i,         // thermal warning
  input  wire logic [NUM_CH*ssr_pkg::OC_W-1:0]  oc_code_i, // overcurrent codes
  input  wire logic [NUM_CH-1:0]           olon_i,        // open load on
  input  wire logic [NUM_CH-1:0]           oloff_i,       // open load off
  input  wire logic                        limp_pin_i,    // limp home pin
  input  wire logic [NUM_IN-1:0]           din_pin_i,     // direct input pins
  input  wire logic [NUM_CH-1:0]           cmp_i,         // half-battery comparators
  input  wire logic [NUM_IN-1:0]           in_on_i        // internal input-on
);
  import ssr_pkg::*;

  localparam int CW = $clog2(DGL_CYC + 1);
  localparam int NP = NUM_IN + 1;
  localparam int BW = $clog2(WORD_W + 1);

  typedef enum logic [0:0] {ST_IDLE, ST_SHIFT} ssr_state_t;

  ssr_state_t        st_q;       // frame state
  logic [WORD_W-1:0] word_d;     // word to present next
  logic [WORD_W-1:0] sh_q;       // output shift register
  logic [WORD_W-1:0] snap_q;     // word shown this frame
  logic [BW-1:0]     bit_q;      // rising edges seen
  logic              rd_done_q;  // full read finished
  logic [3:0]        rd_addr_q;  // address just read
  logic              so_q;       // serial out bit
  logic              so_oe_q;    // serial out enable
  logic [WORD_W-1:0] rx_q;       // captured receive word
  logic              rxv_q;      // receive strobe

  // link pins into the core domain
  logic cs_s1, cs_s2, cs_s3;     // frame select sync
  logic sk_s1, sk_s2, sk_s3;     // link clock sync
  logic dn_s1, dn_s2, dn_s3;     // receive done sync
  logic cs_fall, cs_rise, sk_rise, dn_rise;

  // latched device flags
  logic cpf_q, pwm_clock_fail_flag_q, tmf_q, ovf_q, uvf_q, serial_link_fail_flag_q, rcf_q;

  // per-channel vectors
  logic [NUM_CH-1:0]      ots_v, otw_v, olon_v, oloff_v, ocany_v;
  logic [NUM_CH*OC_W-1:0] oc_v;
  logic [NUM_CH-1:0]      quick_v;
  logic [NUM_CH-1:0]      cmp_s1, cmp_s2;
  logic [NP-1:0]          dgl_v;   // {inputs, limp}

  // summaries
  logic open_load_summary_flag, overload_summary_flag, device_summary_flag;
  logic [2:0] ch_idx;
  logic [DATA_W-1:0] data;

  ssr_link_if #(.WORD_W(WORD_W)) lnk ();

  // receive shifter lives on the link clock
  ssr_sclk_rx #(.WORD_W(WORD_W)) u_rx (
    .sclk_link (sclk_link),
    .cs_n_pin  (cs_n_pin),
    .si_pin    (si_pin),
    .link      (lnk.rx)
  );

  // two-flop sync; third flop only for edges
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      sk_s1 <= 1'b0;
      sk_s2 <= 1'b0;
      sk_s3 <= 1'b0;
      dn_s1 <= 1'b0;
      dn_s2 <= 1'b0;
      dn_s3 <= 1'b0;
    end else begin
      cs_s1 <= cs_n_pin;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      sk_s1 <= sclk_link;
      sk_s2 <= sk_s1;
      sk_s3 <= sk_s2;
      dn_s1 <= lnk.rx_done;
      dn_s2 <= dn_s1;
      dn_s3 <= dn_s2;
    end
  end

  assign cs_fall = cs_s3 & ~cs_s2;
  assign cs_rise = ~cs_s3 & cs_s2;
  assign sk_rise = sk_s2 & ~sk_s3 & ~cs_s2;
  assign dn_rise = dn_s2 & ~dn_s3;

  // receive word held steady while done is high
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_q  <= '0;
      rxv_q <= 1'b0;
    end else begin
      rxv_q <= dn_rise;
      if (dn_rise) begin
        rx_q <= lnk.rx_word;
      end
    end
  end

  // comparators are analog, so synchronise only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cmp_s1 <= '0;
      cmp_s2 <= '0;
    end else begin
      cmp_s1 <= cmp_i;
      cmp_s2 <= cmp_s1;
    end
  end

  // deglitch filters, one per pin
  for (genvar p = 0; p < NP; p++) begin : g_dgl
    logic raw;              // pin level
    logic s1_q, s2_q;       // synchroniser
    logic st_lvl_q;         // accepted level
    logic [CW-1:0] cnt_q;   // stable cycles
    if (p == 0) begin : g_limp
      assign raw = limp_pin_i;
    end else begin : g_din
      assign raw = din_pin_i[p-1];
    end
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        s1_q     <= 1'b0;
        s2_q     <= 1'b0;
        st_lvl_q <= 1'b0;
        cnt_q    <= '0;
      end else begin
        s1_q <= raw;
        s2_q <= s1_q;
        if (s2_q == st_lvl_q) begin
          cnt_q <= '0;
        end else if (cnt_q == CW'(DGL_CYC - 1)) begin
          st_lvl_q <= s2_q;
          cnt_q    <= '0;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
    assign dgl_v[p] = st_lvl_q;
  end

  // channel fault latches; only reported bits clear
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam logic [3:0] CH_ADDR = 4'(REG_CH1 + c);
    logic ots_q, otw_q, olon_q, oloff_q;
    logic [OC_W-1:0] oc_q;
    logic clr;
    assign clr = rd_done_q && (rd_addr_q == CH_ADDR);
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        ots_q   <= FLAG_RST;
        otw_q   <= FLAG_RST;
        olon_q  <= FLAG_RST;
        oloff_q <= FLAG_RST;
        oc_q    <= OC_NONE;
      end else begin
        ots_q   <= ots_i[c] | (ots_q & ~(clr & snap_q[POS_OTS]));
        otw_q   <= otw_i[c] | (otw_q & ~(clr & snap_q[POS_OTW]));
        olon_q  <= olon_i[c] | (olon_q & ~(clr & snap_q[POS_OLON]));
        oloff_q <= oloff_i[c] | (oloff_q & ~(clr & snap_q[POS_OLOFF]));
        // new code wins over the clear
        if (oc_code_i[c*OC_W +: OC_W] != OC_NONE) begin
          oc_q <= oc_code_i[c*OC_W +: OC_W];
        end else if (clr && oc_q == snap_q[POS_OC +: OC_W]) begin
          oc_q <= OC_NONE;
        end
      end
    end
    assign ots_v[c]   = ots_q;
    assign otw_v[c]   = otw_q;
    assign olon_v[c]  = olon_q;
    assign oloff_v[c] = oloff_q;
    assign ocany_v[c] = (oc_q != OC_NONE);
    assign oc_v[c*OC_W +: OC_W] = oc_q;
    assign quick_v[c] = ocany_v[c] | otw_q | ots_q | olon_q | oloff_q;
  end

  // device flags, sticky until shown and read
  // cleared flag starts set
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cpf_q  <= FLAG_RST;
      pwm_clock_fail_flag_q <= FLAG_RST;
      rcf_q  <= RCF_RST;
      tmf_q  <= FLAG_RST;
      ovf_q  <= FLAG_RST;
      uvf_q  <= FLAG_RST;
      serial_link_fail_flag_q <= FLAG_RST;
    end else begin
      cpf_q  <= charge_pump_i | (cpf_q & ~(rd_done_q && rd_addr_q == REG_QUICK && snap_q[POS_CPF]));
      pwm_clock_fail_flag_q <= clk_fail_i | (pwm_clock_fail_flag_q & ~(rd_done_q && rd_addr_q == REG_QUICK && snap_q[POS_PWM_CLOCK_FAIL_FLAG]));
      rcf_q  <= rcf_q & ~(rd_done_q && rd_addr_q == REG_QUICK && snap_q[POS_RCF]);
      tmf_q  <= test_act_i | (tmf_q & ~(rd_done_q && rd_addr_q == REG_DEV && snap_q[POS_TMF]));
      ovf_q  <= supply_high_i | (ovf_q & ~(rd_done_q && rd_addr_q == REG_DEV && snap_q[POS_OVF]));
      uvf_q  <= supply_low_i | (uvf_q & ~(rd_done_q && rd_addr_q == REG_DEV && snap_q[POS_UVF]));
      serial_link_fail_flag_q <= link_fail_i | (serial_link_fail_flag_q & ~(rd_done_q && rd_addr_q == REG_DEV && snap_q[POS_SERIAL_LINK_FAIL_FLAG]));
    end
  end

  assign open_load_summary_flag  = |olon_v | |oloff_v;
  assign overload_summary_flag = |ocany_v | |ots_v;
  // device summary, set by cleared flag at reset
  assign device_summary_flag  = uvf_q | ovf_q | cpf_q | rcf_q | pwm_clock_fail_flag_q | tmf_q;

  assign ch_idx = 3'(next_addr_i - REG_CH1);

  // build data field for the requested address
  // unused addresses and reserved bits read zero
  always_comb begin
    data = '0;
    if (next_addr_i >= REG_QUICK && next_addr_i <= REG_DEV) begin
      data[POS_FM]   = fail_op_i;
      data[POS_DSF]  = device_summary_flag;
      data[POS_OVERLOAD_SUMMARY_FLAG] = overload_summary_flag;
      data[POS_OLF]  = open_load_summary_flag;
    end
    case (next_addr_i)
      REG_QUICK: begin
        data[POS_CPF]  = cpf_q;
        data[POS_RCF]  = rcf_q;
        data[POS_PWM_CLOCK_FAIL_FLAG] = pwm_clock_fail_flag_q;
        data[POS_QS +: NUM_CH] = quick_v;
      end
      REG_DEV: begin
        data[POS_TMF]  = tmf_q;
        data[POS_OVF]  = ovf_q;
        data[POS_UVF]  = uvf_q;
        data[POS_SERIAL_LINK_FAIL_FLAG] = serial_link_fail_flag_q;
        data[POS_LIMP] = dgl_v[0];
      end
      REG_IO: begin
        data[POS_FM] = fail_op_i;
        data[POS_TOGGLE] = |in_on_i;
        data[POS_DIN +: NUM_IN] = dgl_v[NP-1:1];
        data[POS_CMP +: NUM_CH] = cmp_s2;
      end
      REG_ID: begin
        data[POS_FM]     = fail_op_i;
        data[POS_ID_UVF] = uvf_q;
        data[POS_ID_TYPE +: 3] = ID_TYPE;
        data[POS_ID_FAM +: 2]  = ID_FAM;
        data[POS_ID_REV +: 3]  = ID_REV;
      end
      REG_TEST: begin
        data[POS_FM] = 1'b0;
      end
      default: begin
        if (next_addr_i >= REG_CH1 && next_addr_i <= REG_CH5) begin
          data[POS_OTS]        = ots_v[ch_idx];
          data[POS_OTW]        = otw_v[ch_idx];
          data[POS_OC +: OC_W] = oc_v[ch_idx*OC_W +: OC_W];
          data[POS_OLON]       = olon_v[ch_idx];
          data[POS_OLOFF]      = oloff_v[ch_idx];
        end
      end
    endcase
    word_d = {next_addr_i, data};
  end

  // output frame: load at select, shift on rising edges
  // sixteen bits, top first
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q      <= ST_IDLE;
      sh_q      <= '0;
      snap_q    <= '0;
      bit_q     <= '0;
      so_q      <= 1'b0;
      so_oe_q   <= 1'b0;
      rd_done_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      rd_done_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (cs_fall) begin
            sh_q      <= word_d;
            snap_q    <= word_d;
            so_q      <= word_d[WORD_W-1];
            so_oe_q   <= 1'b1;
            bit_q     <= '0;
            rd_addr_q <= word_d[WORD_W-1 -: ADDR_W];
            st_q      <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (cs_rise) begin
            // only a complete frame counts as a read
            so_q      <= 1'b0;
            so_oe_q   <= 1'b0;
            rd_done_q <= (bit_q == BW'(WORD_W));
            st_q      <= ST_IDLE;
          end else if (sk_rise && bit_q < BW'(WORD_W)) begin
            so_q  <= sh_q[WORD_W-1];
            sh_q  <= {sh_q[WORD_W-2:0], 1'b0};
            bit_q <= bit_q + 1'b1;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign so_o       = so_q;
  assign so_oe_o    = so_oe_q;
  assign rx_word_o  = rx_q;
  assign rx_valid_o = rxv_q;
endmodule : ssr_status_readout

// >>> testbench/ssr_spi_master.sv
// serial master model that frames reads toward the block
`timescale 1ns/1ps
module ssr_spi_master #(
  parameter int HALF = 7,  // ticks per sclk half, 84 ns
  parameter int LEAD = 27, // select to first edge
  parameter int GAP  = 84  // deselect time, about 1 us
) (
  output logic      sclk_link, // link clock, still outside frames
  output logic      cs_n_pin,  // frame select, low
  output logic      si_pin,    // data toward block
  input  wire logic so_o,      // data from block
  input  wire logic so_oe_o    // block drives so
);
  logic lclk; // 12 ns base, phase unrelated to mclk
  logic last; // last level seen on so
  // base clock for the link side
  initial begin
    lclk = 1'b0;
    #3.7;
    forever #6 lclk = ~lclk;
  end
  // idle levels
  initial begin
    sclk_link = 1'b0;
    cs_n_pin = 1'b1;
    si_pin = 1'b0;
    last = 1'b0;
  end
  // one frame of up to 16 edges, msb first both ways
  task automatic frame(input logic [15:0] tx, input int edges, output logic [15:0] rx);
    rx = 16'h0000;
    @(posedge lclk);
    cs_n_pin <= 1'b0;
    repeat (LEAD) @(posedge lclk);
    for (int i = 0; i < edges; i++) begin
      sclk_link <= 1'b1;
      si_pin <= tx[15-i];
      repeat (HALF) @(posedge lclk);
      // a released line reads as the inverse of its last level
      last = so_oe_o ? so_o : ~last;
      rx = {rx[14:0], last};
      sclk_link <= 1'b0;
      repeat (HALF) @(posedge lclk);
    end
    repeat (9) @(posedge lclk);
    cs_n_pin <= 1'b1;
    si_pin <= ~si_pin;
    repeat (GAP) @(posedge lclk);
  endtask : frame
endmodule : ssr_spi_master

// >>> testbench/ssr_status_readout_props.sv
// checker for the serial status readout ports
`timescale 1ns/1ps
module ssr_status_readout_props (
  input wire logic        mclk,        // core clock
  input wire logic        rst_n,       // sync reset, low
  input wire logic        cs_n_pin,    // frame select
  input wire logic        so_o,        // serial out
  input wire logic        so_oe_o,     // serial out enable
  input wire logic [3:0]  next_addr_i, // reported address
  input wire logic [15:0] rx_word_o,   // received word
  input wire logic        rx_valid_o   // receive strobe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_reset_quiet: assert property (
    $rose(rst_n) |-> !so_oe_o && !rx_valid_o && rx_word_o == 16'h0000)
    else $error("outputs not quiet after reset");
  chk_oe_launch: assert property (
    $fell(cs_n_pin) |-> !so_oe_o ##1 !so_oe_o ##[1:3] so_oe_o)
    else $error("output enable not timed to select");
  chk_oe_stands: assert property (
    !cs_n_pin [*5] |-> so_oe_o)
    else $error("output enable dropped in frame");
  chk_oe_release: assert property (
    $rose(cs_n_pin) |-> ##[2:5] !so_oe_o)
    else $error("output enable held after deselect");
  chk_so_quiet: assert property (
    !so_oe_o |-> !so_o)
    else $error("serial out high while released");
  chk_so_cause: assert property (
    $changed(so_o) |-> so_oe_o || $past(so_oe_o))
    else $error("serial out moved outside frame");
  chk_first_bit: assert property (
    $rose(so_oe_o) |-> so_o == next_addr_i[3])
    else $error("first bit is not address msb");
  chk_valid_pulse: assert property (
    rx_valid_o |=> !rx_valid_o)
    else $error("receive strobe longer than one cycle");
  chk_word_update: assert property (
    $changed(rx_word_o) |-> rx_valid_o)
    else $error("received word changed without strobe");
endmodule : ssr_status_readout_props

bind ssr_status_readout ssr_status_readout_props i_props (.mclk(mclk), .rst_n(rst_n),
  .cs_n_pin(cs_n_pin), .so_o(so_o), .so_oe_o(so_oe_o), .next_addr_i(next_addr_i),
  .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o));

// >>> testbench/ssr_status_readout_tb_top.sv
// top bench: reads every status word through the master model
`timescale 1ns/1ps
module ssr_status_readout_tb_top;
  import ssr_pkg::*;
  logic        mclk, rst_n, sclk_link, cs_n_pin, si_pin, so_o, so_oe_o, rx_valid_o;
  logic        fail_op_i, charge_pump_i, clk_fail_i, test_act_i;
  logic        supply_high_i, supply_low_i, link_fail_i, limp_pin_i;
  logic [3:0]  next_addr_i, din_pin_i, in_on_i; // address and pins
  logic [4:0]  ots_i, otw_i, olon_i, oloff_i, cmp_i; // per channel
  logic [14:0] oc_code_i; // three bits per channel
  logic [15:0] rx_word_o, seq; // received word, sent word
  int          err_count, compares, cyc, pulses; // counters
  // short deglitch keeps the run brief
  ssr_status_readout #(.DGL_CYC(4)) i_dut (.mclk(mclk), .rst_n(rst_n), .sclk_link(sclk_link),
    .cs_n_pin(cs_n_pin), .si_pin(si_pin), .so_o(so_o), .so_oe_o(so_oe_o), .next_addr_i(next_addr_i),
    .rx_word_o(rx_word_o), .rx_valid_o(rx_valid_o), .fail_op_i(fail_op_i),
    .charge_pump_i(charge_pump_i), .clk_fail_i(clk_fail_i), .test_act_i(test_act_i),
    .supply_high_i(supply_high_i), .supply_low_i(supply_low_i), .link_fail_i(link_fail_i),
    .ots_i(ots_i), .otw_i(otw_i), .oc_code_i(oc_code_i), .olon_i(olon_i), .oloff_i(oloff_i),
    .limp_pin_i(limp_pin_i), .din_pin_i(din_pin_i), .cmp_i(cmp_i), .in_on_i(in_on_i));
  ssr_spi_master i_master (.sclk_link(sclk_link), .cs_n_pin(cs_n_pin), .si_pin(si_pin),
    .so_o(so_o), .so_oe_o(so_oe_o));
  // 100 MHz core clock
  always #5 mclk = ~mclk;
  // hang guard, about twice the expected run
  always @(posedge mclk) begin
    cyc++;
    // receive strobes, compared against full frames at the end
    if (rx_valid_o) pulses++;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // full read of one address, also checks the word shifted in
  task automatic rd(input logic [3:0] addr, input logic [11:0] exp);
    logic [15:0] rx;
    @(posedge mclk);
    next_addr_i <= addr;
    seq = seq + 16'h1f3b;
    @(posedge mclk);
    i_master.frame(seq, 16, rx);
    check(rx, {addr, exp});
    check(rx_word_o, seq);
  endtask : rd
  // reset values, cleared flag, unused places, identity
  task automatic t_reset();
    check({15'h0000, so_oe_o}, 16'h0000);
    rd(REG_QUICK, 12'h440);
    rd(REG_QUICK, 12'h000);
    rd(4'h0, 12'h000);
    rd(REG_TEST, 12'h000);
    rd(REG_IO, 12'h000);
    rd(REG_ID, {4'h0, ID_REV, ID_FAM, ID_TYPE});
  endtask : t_reset
  // each code once, each channel at least once
  task automatic t_channels();
    int ch;
    logic [2:0] code;
    logic s, w, on, off, open_load_summary_flag;
    logic [15:0] rx;
    for (int k = 0; k < 6; k++) begin
      ch = k % 5;
      code = 3'(k + 1);
      s = k[0];
      w = k[1];
      on = ~k[0];
      off = k[2];
      open_load_summary_flag = on | off;
      @(posedge mclk);
      ots_i[ch] <= s;
      otw_i[ch] <= w;
      olon_i[ch] <= on;
      oloff_i[ch] <= off;
      oc_code_i[ch*3+:3] <= code;
      @(posedge mclk);
      {ots_i, otw_i, olon_i, oloff_i, oc_code_i} <= '0;
      // a short frame is no read and must clear nothing
      if (k == 0) begin
        next_addr_i <= REG_CH1;
        i_master.frame(16'h0f0f, 8, rx);
        // eight bits out: address nibble, then fail, summary, overload, open load
        check(rx, 16'h0023);
      end
      rd(REG_QUICK, {3'b001, open_load_summary_flag, 3'b000, 5'(1 << ch)});
      rd(4'(REG_CH1 + ch), {3'b001, open_load_summary_flag, 1'b0, s, w, code, on, off});
      rd(REG_QUICK, 12'h000);
    end
  endtask : t_channels
  // supply flags feed the summary, reads clear them
  task automatic t_device();
    @(posedge mclk);
    {fail_op_i, charge_pump_i, clk_fail_i, test_act_i} <= 4'hf;
    {supply_high_i, supply_low_i, link_fail_i} <= 3'h7;
    @(posedge mclk);
    {charge_pump_i, clk_fail_i, test_act_i, supply_high_i, supply_low_i, link_fail_i} <= '0;
    rd(REG_QUICK, 12'hca0);
    rd(REG_ID, {4'hc, ID_REV, ID_FAM, ID_TYPE});
    rd(REG_DEV, 12'hc1e);
    rd(REG_DEV, 12'h800);
    // frames end on the link clock, so realign before driving
    @(posedge mclk);
    fail_op_i <= 1'b0;
  endtask : t_device
  // live pin levels follow the pins both ways
  task automatic t_pins();
    @(posedge mclk);
    din_pin_i <= 4'b1010;
    limp_pin_i <= 1'b1;
    cmp_i <= 5'b10110;
    in_on_i <= 4'b0100;
    repeat (20) @(posedge mclk);
    rd(REG_IO, 12'h356);
    rd(REG_DEV, 12'h001);
    @(posedge mclk);
    din_pin_i <= 4'b0101;
    limp_pin_i <= 1'b0;
    cmp_i <= 5'b01001;
    in_on_i <= 4'b0000;
    repeat (20) @(posedge mclk);
    rd(REG_IO, 12'h0a9);
    rd(REG_DEV, 12'h000);
    // a two-cycle glitch is shorter than the filter and must not show
    @(posedge mclk);
    din_pin_i <= 4'b1111;
    limp_pin_i <= 1'b1;
    repeat (2) @(posedge mclk);
    din_pin_i <= 4'b0101;
    limp_pin_i <= 1'b0;
    rd(REG_IO, 12'h0a9);
    rd(REG_DEV, 12'h000);
  endtask : t_pins
  // main sequence
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    seq = 16'h5a3c;
    {err_count, compares, cyc, pulses} = '0;
    {fail_op_i, charge_pump_i, clk_fail_i, test_act_i, supply_high_i, supply_low_i} = '0;
    {link_fail_i, limp_pin_i, next_addr_i, din_pin_i, in_on_i} = '0;
    {ots_i, otw_i, olon_i, oloff_i, cmp_i, oc_code_i} = '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (6) @(posedge mclk);
    t_reset();
    t_channels();
    t_device();
    t_pins();
    // thirty-four full frames, one strobe each; short frames raise none
    check(16'(pulses), 16'h0022);
    end_sim();
  end
endmodule : ssr_status_readout_tb_top
